// ### src/bl_defs.vh
// Constants for the backlight driver control register bank
`ifndef BL_DEFS_VH
`define BL_DEFS_VH
`define BL_OFS_SOFT_RESET 8'h01
`define BL_OFS_ENABLE     8'h10
`define BL_OFS_BRT_CTRL   8'h11
`define BL_OFS_CODE_HI    8'h19
`define BL_OFS_CODE_LO    8'h1a
`define BL_OFS_MAXCUR     8'h1b
`define BL_OFS_FAULT      8'h1f
`define BL_SRST_BIT       0
`define BL_EN_HI          3
`define BL_EN_LO          0
`define BL_DEV_EN_BIT     0
`define BL_STR_HI         3
`define BL_STR_LO         1
`define BL_MODE_HI        6
`define BL_MODE_LO        5
`define BL_RAMP_BIT       4
`define BL_NIB_HI         3
`define BL_NIB_LO         0
`define BL_MAXCUR_HI      1
`define BL_MAXCUR_LO      0
`define BL_RST_ENABLE     4'hf
`define BL_RST_MODE       2'h3
`define BL_RST_RAMP       1'h0
`define BL_RST_CODE_HI    8'hff
`define BL_RST_CODE_LO    4'hf
`define BL_RST_MAXCUR     2'h0
`define BL_RSV_SRST       7'h00
`define BL_RSV_ENABLE     4'h1
`define BL_RSV_BRT_TOP    1'h0
`define BL_RSV_BRT_LOW    4'h5
`define BL_RSV_CODE_LO    4'hf
`define BL_RSV_MAXCUR     6'h00
`define BL_RSV_FAULT      3'h0
`define BL_RD_NONE        8'h00
`define BL_MODE_REG       2'h0
`define BL_MODE_PWM       2'h1
`define BL_CODE_ZERO      12'h000
`define BL_CLK_PERIOD_NS  5
`define BL_NS_PER_US      1000
`define BL_RAMP_FAST_US   128
`define BL_RAMP_SLOW_US   1024
`define BL_RAMP_STEP      12'h002
`define BL_LPF_SHIFT      6
`define BL_I2C_ADDR       7'h2c
`define BL_BYTE_BITS      4'h8
`endif

// ### src/bl_pwm_lpf.v
// PWM duty-cycle estimator using a first-order digital low-pass filter
`timescale 1ns/100ps
`include "bl_defs.vh"
module bl_pwm_lpf (
  input  wire        clk,    // System clock
  input  wire        rst_n,  // Synchronous reset, active low
  input  wire        ce,     // Clock enable
  input  wire        pwm,    // PWM input level
  output wire [11:0] duty    // Filtered duty, full scale 4095
);
  reg  [15:0] acc_r;
  wire [15:0] rise_d = 16'hffff - acc_r;
  wire [15:0] rise_s = rise_d >> `BL_LPF_SHIFT;
  wire [15:0] fall_s = acc_r >> `BL_LPF_SHIFT;
  // Minimum step of one so the filter settles exactly at both rails
  wire [15:0] inc = (rise_s == 16'h0000) ? {15'h0000, |rise_d} : rise_s;
  wire [15:0] dec = (fall_s == 16'h0000) ? {15'h0000, |acc_r} : fall_s;

  always @(posedge clk) begin
    if (!rst_n) begin
      acc_r <= 16'h0000;
    end else if (ce) begin
      if (pwm) begin
        acc_r <= acc_r + inc;
      end else begin
        acc_r <= acc_r - dec;
      end
    end
  end

  assign duty = acc_r[15:4];
endmodule // bl_pwm_lpf

// ### src/bl_ramp.v
// Brightness ramp stepper moving the active level toward its target
`timescale 1ns/100ps
`include "bl_defs.vh"
module bl_ramp #(
  parameter [17:0] FAST_CYC = 18'h0_6400,
  parameter [17:0] SLOW_CYC = 18'h3_2000
) (
  input  wire        clk,      // System clock
  input  wire        rst_n,    // Synchronous reset, active low
  input  wire        ce,       // Clock enable
  input  wire        ramp_en,  // Ramp active
  input  wire        fast,     // Short step period selected
  input  wire [11:0] target,   // Requested brightness
  output wire [11:0] level     // Ramped brightness
);
  reg  [17:0] tmr_r;
  reg  [11:0] lvl_r;
  wire [17:0] period = fast ? FAST_CYC : SLOW_CYC;
  wire [11:0] up_gap = target - lvl_r;
  wire [11:0] dn_gap = lvl_r - target;
  reg  [11:0] lvl_nxt;

  always @* begin
    if (target > lvl_r) begin
      lvl_nxt = (up_gap < `BL_RAMP_STEP) ? target : lvl_r + `BL_RAMP_STEP;
    end else begin
      lvl_nxt = (dn_gap < `BL_RAMP_STEP) ? target : lvl_r - `BL_RAMP_STEP;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      tmr_r <= 18'h0_0000;
      lvl_r <= `BL_CODE_ZERO;
    end else if (ce) begin
      if (!ramp_en) begin
        tmr_r <= 18'h0_0000;
        lvl_r <= target;
      end else if (lvl_r == target) begin
        tmr_r <= 18'h0_0000;
      end else if (tmr_r >= period - 18'h0_0001) begin
        tmr_r <= 18'h0_0000;
        lvl_r <= lvl_nxt;
      end else begin
        tmr_r <= tmr_r + 18'h0_0001;
      end
    end
  end

  assign level = lvl_r;
endmodule // bl_ramp

// ### src/bl_ctrl_top.v
// Backlight driver control registers, serial slave and operating state
`timescale 1ns/100ps
`include "bl_defs.vh"
module bl_ctrl_top #(
  parameter [6:0] I2C_ADDR      = `BL_I2C_ADDR, // Arbitrary slave address
  parameter       RAMP_FAST_CYC = `BL_RAMP_FAST_US * `BL_NS_PER_US
                                  / `BL_CLK_PERIOD_NS,
  parameter       RAMP_SLOW_CYC = `BL_RAMP_SLOW_US * `BL_NS_PER_US
                                  / `BL_CLK_PERIOD_NS
) (
  input  wire        MCLK,                   // 200 MHz clock
  input  wire        NRST,                   // Sync reset, active low
  input  wire        CE,                     // Clock enable
  input  wire        HARDWARE_ENABLE_PIN,    // Master enable pin
  input  wire        PWM_IN,                 // PWM dimming input
  input  wire        SCL_IN,                 // Serial clock
  input  wire        SDA_IN,                 // Serial data level
  output wire        SDA_OUT,                // Serial data drive value
  output wire        SDA_OE,                 // Serial data pull low
  input  wire        OPEN_FAULT_IN,          // String open detected
  input  wire        SHORT_FAULT_IN,         // LED short detected
  input  wire        THERMAL_SHUTDOWN_FAULT, // Over-temperature
  input  wire        OVERCURRENT_FAULT,      // Switch current limit
  input  wire        OVERVOLTAGE_FAULT,      // Output overvoltage
  output wire [1:0]  OP_STATE,               // 0 off,1 standby,2 drive,3 boost
  output wire        SHUTDOWN,               // Low-power shutdown
  output wire        BOOST_EN,               // Boost converter run
  output wire [2:0]  STRING_SINK_EN,         // Sinks three..one enable
  output wire [11:0] LED_LEVEL,              // Brightness code to sinks
  output wire [1:0]  MAX_CUR_SEL,            // Maximum string current
  output wire [1:0]  BRIGHT_MODE             // Active brightness mode
);
  localparam [1:0] OP_OFF     = 2'h0;
  localparam [1:0] OP_STANDBY = 2'h1;
  localparam [1:0] OP_DRIVE   = 2'h2;
  localparam [1:0] OP_BOOST   = 2'h3;

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RX   = 3'h1;
  localparam [2:0] S_ACK  = 3'h2;
  localparam [2:0] S_TX   = 3'h3;
  localparam [2:0] S_RACK = 3'h4;

  localparam [1:0] K_ADDR = 2'h0;
  localparam [1:0] K_PTR  = 2'h1;
  localparam [1:0] K_DATA = 2'h2;

  // Serial slave state
  reg  [2:0]  st_r;
  reg  [1:0]  kind_r;
  reg  [3:0]  cnt_r;
  reg  [7:0]  sh_r;
  reg  [7:0]  ptr_r;
  reg         rw_r;
  reg         scl_q;
  reg         sda_q;
  reg         oe_r;
  reg         sda_out_r;
  reg         wr_stb_r;
  reg  [7:0]  wr_ptr_r;
  reg  [7:0]  wr_dat_r;

  // Register bank
  reg         soft_r;
  reg  [3:0]  enable_r;
  reg  [1:0]  mode_r;
  reg         ramp_r;
  reg  [7:0]  code_hi_r;
  reg  [3:0]  code_lo_r;
  reg  [11:0] code_r;
  reg  [1:0]  maxcur_r;
  reg  [4:0]  fault_r;

  // Output flops
  reg  [1:0]  op_r;
  reg         shdn_r;
  reg         boost_r;
  reg  [2:0]  sink_r;
  reg  [11:0] level_r;
  reg  [1:0]  maxcur_out_r;
  reg  [1:0]  mode_out_r;

  reg  [7:0]  rd_data;
  reg  [11:0] target;
  reg  [1:0]  op_nxt;

  wire        hold = !NRST || !HARDWARE_ENABLE_PIN || soft_r;
  wire        scl_rise = SCL_IN && !scl_q;
  wire        scl_fall = !SCL_IN && scl_q;
  wire        start = SCL_IN && scl_q && sda_q && !SDA_IN;
  wire        stop = SCL_IN && scl_q && !sda_q && SDA_IN;
  wire        byte_in = (cnt_r == `BL_BYTE_BITS);
  wire [11:0] duty;
  wire [11:0] ramp_lvl;
  wire [22:0] prod = code_r[11:1] * duty;
  wire        pwm_low = (duty == `BL_CODE_ZERO);
  wire        code_zero = (code_r == `BL_CODE_ZERO);
  wire        dev_en = enable_r[`BL_DEV_EN_BIT];
  wire [2:0]  strings = enable_r[`BL_STR_HI:`BL_STR_LO];
  wire        fast = (code_r[11:8] != 4'h0);
  wire        ramp_on = ramp_r && (mode_r != `BL_MODE_PWM);

  // Reserved positions return fixed patterns regardless of writes
  always @* begin
    case (ptr_r)
      `BL_OFS_SOFT_RESET: rd_data = {`BL_RSV_SRST, 1'b0};
      `BL_OFS_ENABLE:     rd_data = {`BL_RSV_ENABLE, enable_r};
      `BL_OFS_BRT_CTRL:   rd_data = {`BL_RSV_BRT_TOP, mode_r, ramp_r,
                                     `BL_RSV_BRT_LOW};
      `BL_OFS_CODE_HI:    rd_data = code_hi_r;
      `BL_OFS_CODE_LO:    rd_data = {`BL_RSV_CODE_LO, code_lo_r};
      `BL_OFS_MAXCUR:     rd_data = {`BL_RSV_MAXCUR, maxcur_r};
      `BL_OFS_FAULT:      rd_data = {`BL_RSV_FAULT, fault_r};
      default:            rd_data = `BL_RD_NONE;
    endcase
  end

  // Serial slave: pointer byte, then data bytes with auto-increment
  always @(posedge MCLK) begin
    if (!NRST) begin
      st_r      <= S_IDLE;
      kind_r    <= K_ADDR;
      cnt_r     <= 4'h0;
      sh_r      <= 8'h00;
      ptr_r     <= 8'h00;
      rw_r      <= 1'b0;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      oe_r      <= 1'b0;
      sda_out_r <= 1'b0;
      wr_stb_r  <= 1'b0;
      wr_ptr_r  <= 8'h00;
      wr_dat_r  <= 8'h00;
    end else if (CE) begin
      scl_q    <= SCL_IN;
      sda_q    <= SDA_IN;
      wr_stb_r <= 1'b0;
      if (!HARDWARE_ENABLE_PIN) begin
        st_r <= S_IDLE;
        oe_r <= 1'b0;
      end else if (start) begin
        st_r   <= S_RX;
        kind_r <= K_ADDR;
        cnt_r  <= 4'h0;
        oe_r   <= 1'b0;
      end else if (stop) begin
        st_r <= S_IDLE;
        oe_r <= 1'b0;
      end else begin
        case (st_r)
          S_RX: begin
            if (scl_rise) begin
              sh_r  <= {sh_r[6:0], SDA_IN};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && byte_in) begin
              case (kind_r)
                K_ADDR: begin
                  if (sh_r[7:1] == I2C_ADDR) begin
                    rw_r   <= sh_r[0];
                    kind_r <= K_PTR;
                    oe_r   <= 1'b1;
                    st_r   <= S_ACK;
                  end else begin
                    st_r <= S_IDLE;
                  end
                end
                K_PTR: begin
                  ptr_r  <= sh_r;
                  kind_r <= K_DATA;
                  oe_r   <= 1'b1;
                  st_r   <= S_ACK;
                end
                default: begin
                  wr_stb_r <= 1'b1;
                  wr_ptr_r <= ptr_r;
                  wr_dat_r <= sh_r;
                  ptr_r    <= ptr_r + 8'h01;
                  oe_r     <= 1'b1;
                  st_r     <= S_ACK;
                end
              endcase
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              if (rw_r) begin
                sh_r  <= {rd_data[6:0], 1'b0};
                oe_r  <= !rd_data[7];
                cnt_r <= 4'h1;
                ptr_r <= ptr_r + 8'h01;
                st_r  <= S_TX;
              end else begin
                cnt_r <= 4'h0;
                oe_r  <= 1'b0;
                st_r  <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (byte_in) begin
                oe_r <= 1'b0;
                st_r <= S_RACK;
              end else begin
                oe_r  <= !sh_r[7];
                sh_r  <= {sh_r[6:0], 1'b0};
                cnt_r <= cnt_r + 4'h1;
              end
            end
          end
          S_RACK: begin
            // Master not-acknowledge ends the read burst
            if (scl_rise && SDA_IN) begin
              st_r <= S_IDLE;
            end else if (scl_fall) begin
              sh_r  <= {rd_data[6:0], 1'b0};
              oe_r  <= !rd_data[7];
              cnt_r <= 4'h1;
              ptr_r <= ptr_r + 8'h01;
              st_r  <= S_TX;
            end
          end
          default: begin
            st_r <= S_IDLE;
            oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // Register bank; pin low or soft reset forces defaults
  always @(posedge MCLK) begin
    if (hold) begin
      soft_r    <= 1'b0;
      enable_r  <= `BL_RST_ENABLE;
      mode_r    <= `BL_RST_MODE;
      ramp_r    <= `BL_RST_RAMP;
      code_hi_r <= `BL_RST_CODE_HI;
      code_lo_r <= `BL_RST_CODE_LO;
      code_r    <= {`BL_RST_CODE_HI, `BL_RST_CODE_LO};
      maxcur_r  <= `BL_RST_MAXCUR;
      fault_r   <= 5'h00;
    end else if (CE) begin
      fault_r <= {OPEN_FAULT_IN, SHORT_FAULT_IN, THERMAL_SHUTDOWN_FAULT,
                  OVERCURRENT_FAULT, OVERVOLTAGE_FAULT};
      if (wr_stb_r) begin
        // Only defined fields are stored; reserved bits are dropped
        case (wr_ptr_r)
          `BL_OFS_SOFT_RESET: soft_r <= wr_dat_r[`BL_SRST_BIT];
          `BL_OFS_ENABLE:
            enable_r <= wr_dat_r[`BL_EN_HI:`BL_EN_LO];
          `BL_OFS_BRT_CTRL: begin
            mode_r <= wr_dat_r[`BL_MODE_HI:`BL_MODE_LO];
            ramp_r <= wr_dat_r[`BL_RAMP_BIT];
          end
          `BL_OFS_CODE_HI: begin
            code_hi_r <= wr_dat_r;
            code_r    <= {wr_dat_r, code_lo_r};
          end
          `BL_OFS_CODE_LO:
            code_lo_r <= wr_dat_r[`BL_NIB_HI:`BL_NIB_LO];
          `BL_OFS_MAXCUR:
            maxcur_r <= wr_dat_r[`BL_MAXCUR_HI:`BL_MAXCUR_LO];
          default: begin
          end
        endcase
      end
    end
  end

  bl_pwm_lpf u_lpf (
    .clk   (MCLK),
    .rst_n (!hold),
    .ce    (CE),
    .pwm   (PWM_IN),
    .duty  (duty)
  );

  // Mode decides which code sets the brightness
  always @* begin
    case (mode_r)
      `BL_MODE_REG: target = code_r;
      `BL_MODE_PWM: target = {1'b0, duty[11:1]};
      default:      target = {1'b0, prod[22:12]};
    endcase
  end

  bl_ramp #(
    .FAST_CYC (RAMP_FAST_CYC[17:0]),
    .SLOW_CYC (RAMP_SLOW_CYC[17:0])
  ) u_ramp (
    .clk     (MCLK),
    .rst_n   (!hold),
    .ce      (CE),
    .ramp_en (ramp_on),
    .fast    (fast),
    .target  (target),
    .level   (ramp_lvl)
  );

  // Operating state from enables, mode, code and filtered PWM
  always @* begin
    if (!HARDWARE_ENABLE_PIN || !dev_en) begin
      op_nxt = OP_OFF;
    end else if (strings == 3'h0) begin
      op_nxt = OP_BOOST;
    end else if ((mode_r == `BL_MODE_REG && code_zero) ||
                 (mode_r == `BL_MODE_PWM && pwm_low) ||
                 (mode_r[1] && (pwm_low || code_zero))) begin
      op_nxt = OP_STANDBY;
    end else begin
      op_nxt = OP_DRIVE;
    end
  end

  always @(posedge MCLK) begin
    if (!NRST) begin
      op_r         <= OP_OFF;
      shdn_r       <= 1'b1;
      boost_r      <= 1'b0;
      sink_r       <= 3'h0;
      level_r      <= `BL_CODE_ZERO;
      maxcur_out_r <= `BL_RST_MAXCUR;
      mode_out_r   <= `BL_RST_MODE;
    end else if (CE) begin
      op_r         <= op_nxt;
      // Standby idles at shutdown current but keeps the registers
      shdn_r       <= (op_nxt == OP_OFF) || (op_nxt == OP_STANDBY);
      boost_r      <= (op_nxt == OP_DRIVE) || (op_nxt == OP_BOOST);
      sink_r       <= (op_nxt == OP_DRIVE) ? strings : 3'h0;
      level_r      <= (op_nxt == OP_DRIVE) ? ramp_lvl : `BL_CODE_ZERO;
      maxcur_out_r <= maxcur_r;
      mode_out_r   <= mode_r;
    end
  end

  assign SDA_OUT        = sda_out_r;
  assign SDA_OE         = oe_r;
  assign OP_STATE       = op_r;
  assign SHUTDOWN       = shdn_r;
  assign BOOST_EN       = boost_r;
  assign STRING_SINK_EN = sink_r;
  assign LED_LEVEL      = level_r;
  assign MAX_CUR_SEL    = maxcur_out_r;
  assign BRIGHT_MODE    = mode_out_r;
endmodule // bl_ctrl_top

// ### verif/bdc_ctrl_sva.sv
// Assertions on the backlight control bank top-level ports
`timescale 1ns/100ps
module bl_ctrl_sva (
  input wire        MCLK,                // Clock
  input wire        NRST,                // Reset, low
  input wire        CE,                  // Clock enable
  input wire        HARDWARE_ENABLE_PIN, // Master enable
  input wire        SCL_IN,              // Serial clock
  input wire        SDA_OE,              // Pull low
  input wire [1:0]  OP_STATE,            // State
  input wire        SHUTDOWN,            // Low power
  input wire        BOOST_EN,            // Boost run
  input wire [2:0]  STRING_SINK_EN,      // Sinks
  input wire [11:0] LED_LEVEL,           // Level
  input wire [1:0]  MAX_CUR_SEL,         // Current select
  input wire [1:0]  BRIGHT_MODE          // Mode
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!NRST);

  pin_low_quiet_a:
    assert property (!HARDWARE_ENABLE_PIN && CE |=> !SDA_OE)
    else $error("serial slave drives with enable pin low");
  pin_low_default_a:
    assert property (!HARDWARE_ENABLE_PIN [*4] |-> OP_STATE == 2'h0
      && MAX_CUR_SEL == 2'h0 && BRIGHT_MODE == 2'h3)
    else $error("outputs not at defaults with enable pin low");
  off_dark_a:
    assert property (OP_STATE == 2'h0 |-> SHUTDOWN && !BOOST_EN
      && STRING_SINK_EN == 3'h0 && LED_LEVEL == 12'h000)
    else $error("off state drives boost or strings");
  standby_dark_a:
    assert property (OP_STATE == 2'h1 |-> SHUTDOWN && !BOOST_EN
      && STRING_SINK_EN == 3'h0 && LED_LEVEL == 12'h000)
    else $error("standby state drives boost or strings");
  boost_only_a:
    assert property (OP_STATE == 2'h3 |-> BOOST_EN && !SHUTDOWN
      && STRING_SINK_EN == 3'h0 && LED_LEVEL == 12'h000)
    else $error("boost only state drives strings");
  drive_on_a:
    assert property (OP_STATE == 2'h2 |-> BOOST_EN && !SHUTDOWN
      && STRING_SINK_EN != 3'h0)
    else $error("driving state without boost or sinks");
  oe_rise_low_a:
    assert property ($rose(SDA_OE) |-> !SCL_IN && $past(SCL_IN) == 1'b0)
    else $error("data pull starts outside clock low");
  oe_fall_low_a:
    assert property ($fell(SDA_OE) && HARDWARE_ENABLE_PIN |-> !SCL_IN)
    else $error("data pull ends while clock high");
endmodule // bl_ctrl_sva

bind bl_ctrl_top bl_ctrl_sva i_sva (
  .MCLK(MCLK), .NRST(NRST), .CE(CE),
  .HARDWARE_ENABLE_PIN(HARDWARE_ENABLE_PIN), .SCL_IN(SCL_IN),
  .SDA_OE(SDA_OE), .OP_STATE(OP_STATE), .SHUTDOWN(SHUTDOWN),
  .BOOST_EN(BOOST_EN), .STRING_SINK_EN(STRING_SINK_EN),
  .LED_LEVEL(LED_LEVEL), .MAX_CUR_SEL(MAX_CUR_SEL),
  .BRIGHT_MODE(BRIGHT_MODE));

// ### verif/bdc_host_model.sv
// Serial host model driving the register bank's two-wire port
`timescale 1ns/100ps
module bl_host_model #(
  parameter [6:0] ADDR = 7'h2c // Arbitrary slave address
) (
  input  wire mclk,  // System clock
  input  wire sda,   // Resolved data wire
  output reg  scl = 1'b1,  // Serial clock, idles high
  output reg  sda_m = 1'b1 // Data drive, 1 releases
);
  // Four cycles a level, above the three the slave needs
  task automatic ph(input logic c, input logic d);
    @(negedge mclk);
    scl = c;
    sda_m = d;
    repeat (3) @(negedge mclk);
  endtask
  // Clock drops before data moves, so no false start or stop
  task automatic bt(input logic b, output logic r);
    ph(1'b0, sda_m);
    ph(1'b0, b);
    ph(1'b1, b);
    r = sda;
  endtask
  // Zero gives a start, one a stop
  task automatic cond(input logic s);
    ph(1'b0, sda_m);
    ph(1'b0, ~s);
    ph(1'b1, ~s);
    ph(1'b1, s);
  endtask
  task automatic xb(input logic [7:0] tx, input logic m,
                    output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bt(tx[i], r);
      rx[i] = r;
    end
    bt(m, r);
    ack = ~r;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d,
                    output logic ok);
    logic [7:0] rx;
    logic [2:0] a;
    cond(1'b0);
    xb({ADDR, 1'b0}, 1'b1, rx, a[0]);
    xb(p, 1'b1, rx, a[1]);
    xb(d, 1'b1, rx, a[2]);
    cond(1'b1);
    ok = &a;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d,
                    output logic ok);
    logic [7:0] rx;
    logic [3:0] a;
    cond(1'b0);
    xb({ADDR, 1'b0}, 1'b1, rx, a[0]);
    xb(p, 1'b1, rx, a[1]);
    cond(1'b0);
    xb({ADDR, 1'b1}, 1'b1, rx, a[2]);
    xb(8'hff, 1'b1, d, a[3]);
    cond(1'b1);
    ok = &a[2:0];
  endtask
endmodule // bl_host_model

// ### verif/backlight_driver_control_regs_bench.sv
// Self-checking bench for the backlight control register bank
`timescale 1ns/100ps
module backlight_driver_control_regs_bench;
  localparam [6:0] ADDR = 7'h2c; // Arbitrary slave address
  // Short ramp periods keep the run brief
  localparam int FAST_CYC = 8;
  localparam int SLOW_CYC = 32;
  reg         mclk;
  reg         nrst;
  reg         ce;
  wire [11:0] level;
  logic [11:0] lvl_seen;
  reg         hw_en;
  reg         pwm;
  reg  [4:0]  flt;
  wire        scl;
  wire        sda_m;
  wire        sda_oe;
  wire        sda_w;
  wire [1:0]  op_state;
  wire [2:0]  sinks;
  wire [1:0]  max_cur;
  wire [1:0]  mode;
  integer     failures;
  integer     n_tests;
  logic       ack;
  logic [7:0] rdat;
  logic [7:0] def_ptr [8] = '{8'h01, 8'h10, 8'h11, 8'h19, 8'h1a, 8'h1b,
                              8'h1f, 8'h05};
  logic [7:0] def_val [8] = '{8'h00, 8'h1f, 8'h65, 8'hff, 8'hff, 8'h00,
                              8'h00, 8'h00};

  // Pull-up wins unless some party pulls low
  assign sda_w = sda_m & ~sda_oe;

  bl_ctrl_top #(.I2C_ADDR(ADDR), .RAMP_FAST_CYC(FAST_CYC),
    .RAMP_SLOW_CYC(SLOW_CYC))
  i_dut (
    .MCLK(mclk), .NRST(nrst), .CE(ce), .HARDWARE_ENABLE_PIN(hw_en),
    .PWM_IN(pwm), .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(),
    .SDA_OE(sda_oe), .OPEN_FAULT_IN(flt[4]), .SHORT_FAULT_IN(flt[3]),
    .THERMAL_SHUTDOWN_FAULT(flt[2]), .OVERCURRENT_FAULT(flt[1]),
    .OVERVOLTAGE_FAULT(flt[0]), .OP_STATE(op_state), .SHUTDOWN(),
    .BOOST_EN(), .STRING_SINK_EN(sinks), .LED_LEVEL(level),
    .MAX_CUR_SEL(max_cur), .BRIGHT_MODE(mode));

  bl_host_model #(.ADDR(ADDR)) i_host (
    .mclk(mclk), .sda(sda_w), .scl(scl), .sda_m(sda_m));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
    i_host.wr(p, d, ack);
    check(ack, 1'b1);
  endtask
  task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
    i_host.rd(p, rdat, ack);
    check({ack, rdat}, {1'b1, e});
  endtask
  // Filter decay can be slow, so the bound is generous
  task automatic wait_state(input logic [1:0] s);
    int n;
    n = 0;
    while (op_state !== s && n < 30000) begin
      @(negedge mclk);
      n++;
    end
    check(op_state, s);
    if (op_state !== s)
      end_sim;
  endtask
  // Cycles between two level steps while the ramp runs
  task automatic step_gap(input int exp);
    logic [11:0] v;
    int n;
    n = 0;
    v = level;
    while (level === v && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    v = level;
    n = 0;
    while (level === v && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    check(n, exp);
  endtask

  initial begin
    failures = 0;
    n_tests = 0;
    nrst = 1'b0;
    ce = 1'b1;
    hw_en = 1'b0;
    pwm = 1'b0;
    flt = 5'h00;
    repeat (3) @(negedge mclk);
    nrst = 1'b1;
    repeat (2) @(negedge mclk);
    check(op_state, 2'h0);
    hw_en = 1'b1;
    wait_state(2'h1);
    check(mode, 2'h3);
    check(max_cur, 2'h0);
    for (int i = 0; i < 8; i++)
      rd_chk(def_ptr[i], def_val[i]);
    pwm = 1'b1;
    wait_state(2'h2);
    check(sinks, 3'h7);
    wr_reg(8'h10, 8'he5);
    rd_chk(8'h10, 8'h15);
    check(sinks, 3'h2);
    wr_reg(8'h11, 8'hff);
    rd_chk(8'h11, 8'h75);
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h11, {1'b0, m[1:0], 5'h00});
      check(mode, m[1:0]);
    end
    wr_reg(8'h11, 8'h00);
    wr_reg(8'h1a, 8'h01);
    wr_reg(8'h19, 8'h00);
    wait_state(2'h2);
    wr_reg(8'h1a, 8'h00);
    check(op_state, 2'h2);
    wr_reg(8'h19, 8'h00);
    wait_state(2'h1);
    wr_reg(8'h11, 8'h60);
    wait_state(2'h1);
    wr_reg(8'h19, 8'h80);
    wait_state(2'h2);
    pwm = 1'b0;
    wait_state(2'h1);
    wr_reg(8'h11, 8'h20);
    rd_chk(8'h11, 8'h25);
    pwm = 1'b1;
    wait_state(2'h2);
    wr_reg(8'h10, 8'h1e);
    wait_state(2'h0);
    wr_reg(8'h10, 8'h11);
    wait_state(2'h3);
    check(sinks, 3'h0);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h1b, {6'h3f, i[1:0]});
      rd_chk(8'h1b, {6'h00, i[1:0]});
      check(max_cur, i[1:0]);
    end
    for (int i = 0; i < 5; i++) begin
      flt = 5'h01 << i;
      rd_chk(8'h1f, {3'h0, flt});
    end
    flt = 5'h00;
    wr_reg(8'h01, 8'h01);
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h10, 8'h1f);
    rd_chk(8'h1b, 8'h00);
    wr_reg(8'h1b, 8'h03);
    hw_en = 1'b0;
    repeat (4) @(negedge mclk);
    check(op_state, 2'h0);
    check(max_cur, 2'h0);
    i_host.rd(8'h1b, rdat, ack);
    check(ack, 1'b0);
    hw_en = 1'b1;
    rd_chk(8'h1b, 8'h00);
    wr_reg(8'h11, 8'h00);
    wr_reg(8'h1a, 8'h00);
    wr_reg(8'h19, 8'h10);
    check(level, 12'h100);
    wr_reg(8'h11, 8'h10);
    wr_reg(8'h19, 8'h18);
    step_gap(FAST_CYC);
    wr_reg(8'h19, 8'h01);
    step_gap(SLOW_CYC);
    // Clock enable low must freeze the running ramp
    ce = 1'b0;
    lvl_seen = level;
    repeat (2 * SLOW_CYC) @(negedge mclk);
    check(level, lvl_seen);
    ce = 1'b1;
    step_gap(SLOW_CYC);
    end_sim;
  end
endmodule // backlight_driver_control_regs_bench
